//--- rtl/mtt_pkg.sv
// Constants, register layout and helpers of the memory access throttle.
// Assumes one 25 MHz clock and a 32-bit Avalon-MM register bus.
package mtt_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 40;

  // Byte offsets of the register words
  localparam logic [4:0] OFF_RD_CTRL_LO = 5'h00;
  localparam logic [4:0] OFF_RD_CTRL_HI = 5'h04;
  localparam logic [4:0] OFF_WR_CTRL_LO = 5'h08;
  localparam logic [4:0] OFF_WR_CTRL_HI = 5'h0C;
  localparam logic [4:0] OFF_GWIN       = 5'h10;
  localparam logic [4:0] OFF_STATUS     = 5'h14;
  localparam logic [4:0] OFF_RD_BLKCNT  = 5'h18;
  localparam logic [4:0] OFF_WR_BLKCNT  = 5'h1C;

  // Low control word fields
  localparam int FORCE_BIT  = 0;
  localparam int MODE_LSB   = 1;
  localparam int LOCK_LSB   = 6;
  localparam int DUR_LSB    = 8;
  localparam int THR_LSB    = 16;
  // High control word fields
  localparam int HMAX_LSB   = 0;
  localparam int MWIN_LSB   = 16;

  // Implemented bits of the low words; lock exists only in the write word
  localparam logic [31:0] RD_LO_USED = 32'hFFFF_FF07;
  localparam logic [31:0] WR_LO_USED = 32'hFFFF_FFC7;
  localparam logic [31:0] FORCE_MASK = 32'h0000_0001;

  // Throttle mode value that selects the counter trigger
  localparam logic [1:0] MODE_COUNTER = 2'h1;

  // Lock field values
  localparam logic [1:0] LOCK_NONE     = 2'h0;
  localparam logic [1:0] LOCK_BUT_FORCE = 2'h1;

  // Reset values
  localparam logic [31:0] CTRL_LO_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_HI_RST = 32'hFFFF_FFFF;
  localparam logic [15:0] GWIN_RST    = 16'h1000;

  // Saturating increment
  function automatic logic [15:0] sat_inc(input logic [15:0] v,
                                          input logic        en);
    if (en && v != 16'hFFFF) begin
      return v + 16'h0001;
    end
    return v;
  endfunction

  // Merge write data into a word under byte enables and a writable mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdata,
                                        input logic [3:0]  be,
                                        input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~m) | (wdata & m);
  endfunction

endpackage

//--- rtl/mtt_chan.sv
// One throttle channel: global window counting, duration and allowance.
// Assumes access pulses and window ticks come from logic on i_clk.
`timescale 1ns/1ns
module mtt_chan (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_gtick,
  input  wire logic        i_force,
  input  wire logic [1:0]  i_mode,
  input  wire logic [7:0]  i_duration,
  input  wire logic [15:0] i_threshold,
  input  wire logic [15:0] i_hex_max,
  input  wire logic [15:0] i_mon_window,
  input  wire logic        i_access,
  output logic             o_active,
  output logic             o_block
);

  logic [15:0] gcount;
  logic [15:0] allow;
  logic [15:0] mon_cnt;
  logic [7:0]  remain;
  logic [7:0]  next_remain;
  logic [15:0] next_allow;
  logic        take;
  logic        mtick;
  logic        trig;
  logic        next_active;

  assign take  = i_access && !o_block;
  assign mtick = (i_mon_window <= 16'h0001) ||
                 (mon_cnt >= i_mon_window - 16'h0001);
  assign trig  = i_gtick && (i_mode == mtt_pkg::MODE_COUNTER) &&
                 (mtt_pkg::sat_inc(gcount, take) > i_threshold);

  always_comb begin
    next_remain = remain;
    if (trig) begin
      next_remain = i_duration;
    end else if (i_gtick && remain != 8'h00) begin
      next_remain = remain - 8'h01;
    end
  end

  assign next_active = i_force || (next_remain != 8'h00);

  always_comb begin
    next_allow = allow;
    if (mtick) begin
      next_allow = 16'h0000;
    end else if (o_active) begin
      next_allow = mtt_pkg::sat_inc(allow, take);
    end
  end

  // Monitoring window timer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mon_cnt <= 16'h0000;
    end else if (mtick) begin
      mon_cnt <= 16'h0000;
    end else begin
      mon_cnt <= mon_cnt + 16'h0001;
    end
  end

  // Hexwords per global window
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gcount <= 16'h0000;
    end else if (i_gtick) begin
      gcount <= 16'h0000;
    end else begin
      gcount <= mtt_pkg::sat_inc(gcount, take);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      remain   <= 8'h00;
      allow    <= 16'h0000;
      o_active <= 1'b0;
      o_block  <= 1'b0;
    end else begin
      remain   <= next_remain;
      allow    <= next_allow;
      o_active <= next_active;
      o_block  <= next_active && (next_allow >= i_hex_max);
    end
  end

  a_force_active: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_force |=> o_active) else $error("forced throttle not active");
  a_block_cause: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_block |-> o_active && allow >= $past(i_hex_max))
    else $error("block without reaching max");
  a_mode_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_gtick && i_mode != mtt_pkg::MODE_COUNTER && remain == 8'h00)
    |=> remain == 8'h00) else $error("trigger outside counter mode");
  a_count_word: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (take && !i_gtick && gcount != 16'hFFFF) |=>
    gcount == $past(gcount) + 16'h0001) else $error("hexword miss");
  a_trig_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    trig |=> remain == $past(i_duration))
    else $error("duration not loaded");
  a_dur_step: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_gtick && !trig && remain != 8'h00) |=>
    remain == $past(remain) - 8'h01) else $error("bad duration step");
  a_win_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    mtick |=> allow == 16'h0000 ##0 (!o_block || i_hex_max == 16'h0000)
    [*1]) else $error("allowance not cleared");
  a_gwin_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_gtick |=> gcount == 16'h0000)
    else $error("global count not cleared");

endmodule

//--- rtl/mtt_top.sv
// Memory access throttle: register file on Avalon-MM and two channels.
// Assumes the request pipeline and register master share i_clk; the
// scheduler stalls a direction while its block output is high.
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module mtt_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [4:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  input  wire logic        i_rd_access,
  input  wire logic        i_wr_access,
  output logic             o_rd_block,
  output logic             o_wr_block,
  output logic             o_rd_active,
  output logic             o_wr_active
);

  logic [31:0] rd_lo;
  logic [31:0] rd_hi;
  logic [31:0] wr_lo;
  logic [31:0] wr_hi;
  logic [15:0] gwin;
  logic [15:0] gwin_cnt;
  logic        gtick;
  logic [31:0] rd_blkcnt;
  logic [31:0] wr_blkcnt;
  logic [1:0]  lock;
  logic [31:0] lo_mask;
  logic [31:0] hi_mask;
  logic        req;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] next_rdata;

  assign req   = i_read || i_write;
  assign wr_go = i_write && !o_waitrequest;
  assign rd_go = i_read && o_waitrequest;
  assign lock  = wr_lo[mtt_pkg::LOCK_LSB +: 2];

  // Writable bits under the current lock mode
  always_comb begin
    lo_mask = 32'hFFFF_FFFF;
    hi_mask = 32'hFFFF_FFFF;
    if (lock == mtt_pkg::LOCK_BUT_FORCE) begin
      lo_mask = mtt_pkg::FORCE_MASK;
      hi_mask = 32'h0000_0000;
    end else if (lock != mtt_pkg::LOCK_NONE) begin
      lo_mask = 32'h0000_0000;
      hi_mask = 32'h0000_0000;
    end
  end

  // Wait state: one cycle high, then low for the completing edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_waitrequest <= 1'b1;
    end else if (req && o_waitrequest) begin
      o_waitrequest <= 1'b0;
    end else begin
      o_waitrequest <= 1'b1;
    end
  end

  // Read channel control
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_lo <= mtt_pkg::CTRL_LO_RST;
      rd_hi <= mtt_pkg::CTRL_HI_RST;
    end else if (wr_go && i_address == mtt_pkg::OFF_RD_CTRL_LO) begin
      rd_lo <= mtt_pkg::merge(rd_lo, i_writedata, i_byteenable,
                              lo_mask & mtt_pkg::RD_LO_USED);
    end else if (wr_go && i_address == mtt_pkg::OFF_RD_CTRL_HI) begin
      rd_hi <= mtt_pkg::merge(rd_hi, i_writedata, i_byteenable,
                              hi_mask);
    end
  end

  // Write channel control, holding the lock field
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_lo <= mtt_pkg::CTRL_LO_RST;
      wr_hi <= mtt_pkg::CTRL_HI_RST;
    end else if (wr_go && i_address == mtt_pkg::OFF_WR_CTRL_LO) begin
      wr_lo <= mtt_pkg::merge(wr_lo, i_writedata, i_byteenable,
                              lo_mask & mtt_pkg::WR_LO_USED);
    end else if (wr_go && i_address == mtt_pkg::OFF_WR_CTRL_HI) begin
      wr_hi <= mtt_pkg::merge(wr_hi, i_writedata, i_byteenable,
                              hi_mask);
    end
  end

  // Global sampling window length, shared by both channels
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gwin <= mtt_pkg::GWIN_RST;
    end else if (wr_go && i_address == mtt_pkg::OFF_GWIN &&
                 lock == mtt_pkg::LOCK_NONE) begin
      gwin <= 16'(mtt_pkg::merge({16'h0000, gwin}, i_writedata,
                                 i_byteenable, 32'h0000_FFFF));
    end
  end

  assign gtick = (gwin <= 16'h0001) || (gwin_cnt >= gwin - 16'h0001);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gwin_cnt <= 16'h0000;
    end else if (gtick) begin
      gwin_cnt <= 16'h0000;
    end else begin
      gwin_cnt <= gwin_cnt + 16'h0001;
    end
  end

  mtt_chan u_rd (
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_gtick      (gtick),
    .i_force      (rd_lo[mtt_pkg::FORCE_BIT]),
    .i_mode       (rd_lo[mtt_pkg::MODE_LSB +: 2]),
    .i_duration   (rd_lo[mtt_pkg::DUR_LSB +: 8]),
    .i_threshold  (rd_lo[mtt_pkg::THR_LSB +: 16]),
    .i_hex_max    (rd_hi[mtt_pkg::HMAX_LSB +: 16]),
    .i_mon_window (rd_hi[mtt_pkg::MWIN_LSB +: 16]),
    .i_access     (i_rd_access),
    .o_active     (o_rd_active),
    .o_block      (o_rd_block)
  );

  mtt_chan u_wr (
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_gtick      (gtick),
    .i_force      (wr_lo[mtt_pkg::FORCE_BIT]),
    .i_mode       (wr_lo[mtt_pkg::MODE_LSB +: 2]),
    .i_duration   (wr_lo[mtt_pkg::DUR_LSB +: 8]),
    .i_threshold  (wr_lo[mtt_pkg::THR_LSB +: 16]),
    .i_hex_max    (wr_hi[mtt_pkg::HMAX_LSB +: 16]),
    .i_mon_window (wr_hi[mtt_pkg::MWIN_LSB +: 16]),
    .i_access     (i_wr_access),
    .o_active     (o_wr_active),
    .o_block      (o_wr_block)
  );

  // Cycles spent blocked, per direction
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_blkcnt <= 32'h0000_0000;
      wr_blkcnt <= 32'h0000_0000;
    end else begin
      if (o_rd_block && rd_blkcnt != 32'hFFFF_FFFF) begin
        rd_blkcnt <= rd_blkcnt + 32'h0000_0001;
      end
      if (o_wr_block && wr_blkcnt != 32'hFFFF_FFFF) begin
        wr_blkcnt <= wr_blkcnt + 32'h0000_0001;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (i_address)
      mtt_pkg::OFF_RD_CTRL_LO: next_rdata = rd_lo;
      mtt_pkg::OFF_RD_CTRL_HI: next_rdata = rd_hi;
      mtt_pkg::OFF_WR_CTRL_LO: next_rdata = wr_lo;
      mtt_pkg::OFF_WR_CTRL_HI: next_rdata = wr_hi;
      mtt_pkg::OFF_GWIN:       next_rdata = {16'h0000, gwin};
      mtt_pkg::OFF_STATUS:     next_rdata = {28'h0000000, o_wr_block,
                                             o_rd_block, o_wr_active,
                                             o_rd_active};
      mtt_pkg::OFF_RD_BLKCNT:  next_rdata = rd_blkcnt;
      mtt_pkg::OFF_WR_BLKCNT:  next_rdata = wr_blkcnt;
      default:                 next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      o_readdata <= next_rdata;
    end
  end

  a_bus_wait: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (req && o_waitrequest) |=> !o_waitrequest ##1 o_waitrequest)
    else $error("wait state not one cycle");
  a_chan_indep: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_go && i_address == mtt_pkg::OFF_RD_CTRL_LO) |=> $stable(wr_lo))
    else $error("read write touched write control");
  a_lock_both: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_go && lock != mtt_pkg::LOCK_NONE &&
     i_address == mtt_pkg::OFF_RD_CTRL_HI) |=> $stable(rd_hi))
    else $error("locked read control changed");
  a_lock_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    lock != mtt_pkg::LOCK_NONE |=> $stable(wr_hi) && $stable(gwin) &&
    lock == $past(lock)) else $error("locked bits changed");
  a_lock_force: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_go && lock == mtt_pkg::LOCK_BUT_FORCE && i_byteenable[0] &&
     i_address == mtt_pkg::OFF_RD_CTRL_LO) |=>
    rd_lo[0] == $past(i_writedata[0]) &&
    rd_lo[31:1] == $past(rd_lo[31:1]))
    else $error("force bit lock mode wrong");
  a_lock_all: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (lock != mtt_pkg::LOCK_NONE && lock != mtt_pkg::LOCK_BUT_FORCE)
    |=> $stable(rd_lo) && $stable(wr_lo))
    else $error("full lock not holding");

endmodule

//--- testbench/mtt_partner.sv
// Model of the request pipeline and scheduler facing the throttle.
// Assumes the bench raises an offer enable per direction on i_clk.
`timescale 1ns/1ns
module mtt_partner (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_rd_en,
  input  wire logic i_wr_en,
  input  wire logic i_rd_block,
  input  wire logic i_wr_block,
  output logic      o_rd_access,
  output logic      o_wr_access,
  output int        o_rd_grants,
  output int        o_wr_grants
);
  // Offers one hexword a cycle while enabled, blocked or not
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_access <= 1'b0;
      o_wr_access <= 1'b0;
    end else begin
      o_rd_access <= i_rd_en;
      o_wr_access <= i_wr_en;
    end
  end

  // Counts hexwords the throttle let through
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_grants <= 0;
      o_wr_grants <= 0;
    end else begin
      if (o_rd_access && !i_rd_block) begin
        o_rd_grants <= o_rd_grants + 1;
      end
      if (o_wr_access && !i_wr_block) begin
        o_wr_grants <= o_wr_grants + 1;
      end
    end
  end
endmodule

//--- testbench/test_mtt_top.sv
// Self-checking bench of the memory access throttle.
// Assumes mtt_top, mtt_pkg and mtt_partner are compiled first.
`timescale 1ns/1ns
module test_mtt_top;
  logic        i_clk;
  logic        i_rst_b;
  logic [4:0]  i_address;
  logic        i_read;
  logic        i_write;
  logic [31:0] i_writedata;
  logic [3:0]  i_byteenable;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic        rd_access;
  logic        wr_access;
  logic        o_rd_block;
  logic        o_wr_block;
  logic        o_rd_active;
  logic        o_wr_active;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] rdata;
  int          rd_g;
  int          wr_g;
  int          base;
  int          act_cnt;
  int          n_errors;
  int          check_count;
  localparam logic [31:0] RSTV [8] = '{32'h0, 32'hFFFF_FFFF, 32'h0,
    32'hFFFF_FFFF, 32'h0000_1000, 32'h0, 32'h0, 32'h0};

  mtt_top mtt_top_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_rd_access(rd_access), .i_wr_access(wr_access),
    .o_rd_block(o_rd_block), .o_wr_block(o_wr_block),
    .o_rd_active(o_rd_active), .o_wr_active(o_wr_active));

  mtt_partner mtt_partner_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_rd_en(rd_en), .i_wr_en(wr_en), .i_rd_block(o_rd_block),
    .i_wr_block(o_wr_block), .o_rd_access(rd_access),
    .o_wr_access(wr_access), .o_rd_grants(rd_g), .o_wr_grants(wr_g));

  // Cycles with write throttling in effect
  always @(posedge i_clk) begin
    if (o_wr_active === 1'b1) begin
      act_cnt <= act_cnt + 1;
    end
  end

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic end_of_test();
    $display("Errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("Error at %0t: count %0d outside range", $time, got);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_read <= !wr;
    i_write <= wr;
    for (k = 0; k < 50; k++) begin
      @(posedge i_clk);
      if (o_waitrequest === 1'b0) break;
    end
    if (k == 50) begin
      n_errors++;
      $display("Error at %0t: bus answer missing", $time);
      end_of_test();
    end
    rdata = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic offer(input logic r, input logic w, input int n);
    @(posedge i_clk);
    rd_en <= r;
    wr_en <= w;
    repeat (n) @(posedge i_clk);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
  endtask

  task automatic chk_resets();
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4), RSTV[i]);
    end
  endtask

  initial begin
    #(40 * 20000);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    {i_rst_b, i_read, i_write, rd_en, wr_en} = '0;
    i_address = 5'h00;
    i_writedata = 32'h0;
    i_byteenable = 4'hF;
    n_errors = 0;
    check_count = 0;
    act_cnt = 0;
    do_reset();
    chk_resets();
    // Read word has no lock field
    wr(mtt_pkg::OFF_RD_CTRL_LO, 32'hFFFF_FFFF);
    rd(mtt_pkg::OFF_RD_CTRL_LO, 32'hFFFF_FF07);
    wr(mtt_pkg::OFF_RD_CTRL_LO, 32'h0);
    wr(mtt_pkg::OFF_GWIN, 32'h10);
    rd(mtt_pkg::OFF_GWIN, 32'h10);
    // Forced read throttle, 3 hexwords per 20 cycles
    wr(mtt_pkg::OFF_RD_CTRL_HI, 32'h0014_0003);
    wr(mtt_pkg::OFF_RD_CTRL_LO, 32'h1);
    repeat (2) @(posedge i_clk);
    chk(o_rd_active, 1'b1);
    chk(o_rd_block, 1'b0);
    base = rd_g;
    chk_rng(wr_g, 0, 0);
    offer(1'b1, 1'b1, 200);
    chk_rng(rd_g - base, 27, 33);
    chk_rng(wr_g, 200, 200);
    repeat (24) @(posedge i_clk);
    bus(1'b0, mtt_pkg::OFF_STATUS, 32'h0);
    chk(rdata[2:0] & 3'h5, 3'h1);
    wr(mtt_pkg::OFF_RD_CTRL_LO, 32'h0);
    repeat (2) @(posedge i_clk);
    chk(o_rd_active, 1'b0);
    base = rd_g;
    offer(1'b1, 1'b0, 40);
    chk_rng(rd_g - base, 40, 40);
    // Counter trigger: threshold 5, duration 3, hexword max 0
    wr(mtt_pkg::OFF_WR_CTRL_HI, 32'h0014_0000);
    wr(mtt_pkg::OFF_WR_CTRL_LO, 32'h0005_0304);
    base = wr_g;
    offer(1'b0, 1'b1, 40);
    chk_rng(wr_g - base, 40, 40);
    repeat (20) @(posedge i_clk);
    wr(mtt_pkg::OFF_WR_CTRL_LO, 32'h0005_0302);
    base = wr_g;
    repeat (5) offer(1'b0, 1'b1, 1);
    repeat (40) @(posedge i_clk);
    chk_rng(wr_g - base, 5, 5);
    chk_rng(act_cnt, 0, 0);
    offer(1'b0, 1'b1, 24);
    repeat (120) @(posedge i_clk);
    chk_rng(act_cnt, 48, 48);
    // Lock leaving only force bits open
    wr(mtt_pkg::OFF_WR_CTRL_LO, 32'h0000_0040);
    rd(mtt_pkg::OFF_WR_CTRL_LO, 32'h0000_0040);
    wr(mtt_pkg::OFF_RD_CTRL_LO, 32'hFFFF_FFFF);
    rd(mtt_pkg::OFF_RD_CTRL_LO, 32'h0000_0001);
    wr(mtt_pkg::OFF_RD_CTRL_HI, 32'h0);
    rd(mtt_pkg::OFF_RD_CTRL_HI, 32'h0014_0003);
    wr(mtt_pkg::OFF_GWIN, 32'h5);
    rd(mtt_pkg::OFF_GWIN, 32'h10);
    wr(mtt_pkg::OFF_WR_CTRL_LO, 32'h0000_0001);
    rd(mtt_pkg::OFF_WR_CTRL_LO, 32'h0000_0041);
    repeat (2) @(posedge i_clk);
    chk(o_wr_active, 1'b1);
    do_reset();
    chk_resets();
    // Full lock freezes force bits too
    wr(mtt_pkg::OFF_WR_CTRL_LO, 32'h0000_0080);
    wr(mtt_pkg::OFF_RD_CTRL_LO, 32'h0000_0001);
    rd(mtt_pkg::OFF_RD_CTRL_LO, 32'h0);
    wr(mtt_pkg::OFF_WR_CTRL_LO, 32'h0000_0001);
    rd(mtt_pkg::OFF_WR_CTRL_LO, 32'h0000_0080);
    end_of_test();
  end
endmodule
